/* File: core/bytio_pkg.sv */
// Shared constants and types for the byte port and its host end
`default_nettype none
package bytio_pkg;
  localparam int unsigned BYTIO_WIDTH = 8;
  localparam logic        BYTIO_MODE_INPUT  = 1'b0;
  localparam logic        BYTIO_MODE_OUTPUT = 1'b1;
  localparam logic [7:0]  BYTIO_CLEAR_VALUE = 8'h00;
  // Host sequencer lengths in system clock cycles
  localparam int unsigned BYTIO_STROBE_CYCLES = 4;
  localparam int unsigned BYTIO_SELECT_CYCLES = 4;
  localparam int unsigned BYTIO_CNT_W         = 3;
  // Host sequencer states, Gray coded in the order listed
  typedef enum logic [2:0] {
    BYTIO_IDLE   = 3'b000,
    BYTIO_EARLY  = 3'b001,
    BYTIO_SELECT = 3'b011,
    BYTIO_PULSE  = 3'b010,
    BYTIO_TAKE   = 3'b110,
    BYTIO_DONE   = 3'b111
  } bytio_state_e;
endpackage
`default_nettype wire

/* File: core/bytio_if.sv */
// Pin-level interface joining the port and its host or peripheral end
`default_nettype none
interface bytio_if;
  logic       mode;
  logic       select_one;
  logic       select_two;
  logic       latch_enable;
  logic       clear_n;
  logic [7:0] port_in_bits;
  logic [7:0] port_out_bits;
  logic       port_out_en;
  logic       service_request;
  modport port (
    input  mode, select_one, select_two, latch_enable, clear_n,
           port_in_bits,
    output port_out_bits, port_out_en, service_request
  );
  modport host (
    output mode, select_one, select_two, latch_enable, clear_n,
           port_in_bits,
    input  port_out_bits, port_out_en, service_request
  );
endinterface
`default_nettype wire

/* File: core/bytio_port.sv */
// The byte-wide mode-programmable port with service request handshake
// What this block does
// - Mode low is input port, high output
// - Input: follow pins while strobe high, hold after
// - Input: request goes low at strobe fall
// - Input: drive outputs only when both selects high
// - Selected outputs: pins, held byte, or zeros
// - Input: request high on deselect or clear
// - Output mode: drivers always enabled
// - Output: load while select pattern, clock high
// - Output: clock low gives zeros or held byte
// - Output: request low at clock fall, high on deselect
// - Peripheral takes request high as data valid
// - Host polls low request, selects, reads
// - Host writes byte, pulses clock, deselects
// - Brief input selection sets request latch
// - Host decodes selects after early pulse
`default_nettype none
module bytio_port
  import bytio_pkg::*;
#(
  parameter int unsigned WIDTH = BYTIO_WIDTH
) (
  // System
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Pins
  bytio_if.port                 pins
);
  logic [WIDTH-1:0] hold_q, hold_d;
  logic             le_q, le_d;
  logic             req_q, req_d;
  logic [WIDTH-1:0] out_q, out_d;
  logic             oe_q, oe_d;
  logic             sel_q, sel_d;
  logic             in_mode, sel_in, sel_out, load;

  function automatic logic [WIDTH-1:0] shown(input logic le,
      input logic clr_n, input logic [WIDTH-1:0] din,
      input logic [WIDTH-1:0] held);
    if (le)
      shown = din;
    else if (!clr_n)
      shown = WIDTH'(BYTIO_CLEAR_VALUE);
    else
      shown = held;
  endfunction

  // Latch state and request flag next values
  always_comb
  begin
    in_mode = (pins.mode == BYTIO_MODE_INPUT);
    sel_in  = pins.select_one & pins.select_two;
    sel_out = ~pins.select_one & pins.select_two;
    load    = pins.latch_enable & (in_mode | sel_out);
    le_d    = load;
    // Remember the mode's select pattern so deselection is an edge
    sel_d   = in_mode ? sel_in : sel_out;
    hold_d  = hold_q;
    if (load)
      hold_d = pins.port_in_bits;
    else if (!pins.clear_n)
      hold_d = WIDTH'(BYTIO_CLEAR_VALUE);
    req_d = req_q;
    if (in_mode)
    begin
      // Request stored active low, so 1 means flag idle
      if (!pins.clear_n || (sel_q && !sel_in))
        req_d = 1'b1;
      if (le_q && !pins.latch_enable)
        req_d = 1'b0;
      if (sel_in)
        req_d = 1'b0;
    end
    else
    begin
      // Falling clock and clear win over deselect
      if (sel_q && !sel_out)
        req_d = 1'b1;
      if ((le_q && !pins.latch_enable) || !pins.clear_n)
        req_d = 1'b0;
    end
    oe_d  = in_mode ? sel_in : 1'b1;
    out_d = shown(load, pins.clear_n, pins.port_in_bits,
                  hold_q);
    if (!oe_d)
      out_d = WIDTH'(BYTIO_CLEAR_VALUE);
  end

  // Registers; output pins lag the pins by one clock
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      hold_q <= WIDTH'(BYTIO_CLEAR_VALUE);
      le_q   <= 1'b0;
      req_q  <= 1'b1;
      out_q  <= WIDTH'(BYTIO_CLEAR_VALUE);
      oe_q   <= 1'b0;
      sel_q  <= 1'b0;
    end
    else
    begin
      sel_q  <= sel_d;
      hold_q <= hold_d;
      le_q   <= le_d;
      req_q  <= req_d;
      out_q  <= out_d;
      oe_q   <= oe_d;
    end
  end

  assign pins.port_out_bits   = out_q;
  assign pins.port_out_en     = oe_q;
  assign pins.service_request = req_q;
endmodule
`default_nettype wire

/* File: core/bytio_host.sv */
// Host end: drives mode, selects, clock and data; reads back bytes
`default_nettype none
module bytio_host
  import bytio_pkg::*;
#(
  parameter logic MODE = BYTIO_MODE_INPUT
) (
  // System
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // User side
  input  wire logic       user_go,
  input  wire logic [7:0] user_wdata,
  output logic            user_busy,
  output logic [7:0]      user_rdata,
  output logic            user_rvalid,
  output logic            user_clear_n,
  // Pins
  bytio_if.host           pins
);
  bytio_state_e st_q, st_d;
  logic [BYTIO_CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0] wd_q, wd_d, rd_q, rd_d;
  logic       rv_q, rv_d;

  // Sequencer: input mode polls request, output mode writes
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    wd_d  = wd_q;
    rd_d  = rd_q;
    rv_d  = 1'b0;
    case (st_q)
      BYTIO_IDLE:
        if (MODE == BYTIO_MODE_INPUT && !pins.service_request)
          st_d = BYTIO_EARLY;
        else if (user_go)
        begin
          // Input mode: act as the peripheral and strobe the byte in
          wd_d  = user_wdata;
          cnt_d = '0;
          st_d  = (MODE == BYTIO_MODE_INPUT) ? BYTIO_PULSE : BYTIO_EARLY;
        end
      BYTIO_EARLY:
      begin
        cnt_d = '0;
        st_d  = BYTIO_SELECT;
      end
      BYTIO_SELECT:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == BYTIO_CNT_W'(BYTIO_SELECT_CYCLES - 1))
        begin
          cnt_d = '0;
          st_d  = (MODE == BYTIO_MODE_INPUT) ? BYTIO_TAKE : BYTIO_PULSE;
        end
      end
      BYTIO_PULSE:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == BYTIO_CNT_W'(BYTIO_STROBE_CYCLES - 1))
        begin
          cnt_d = '0;
          st_d  = BYTIO_DONE;
        end
      end
      BYTIO_TAKE:
      begin
        rd_d = pins.port_out_bits;
        rv_d = 1'b1;
        st_d = BYTIO_DONE;
      end
      BYTIO_DONE:
        st_d = BYTIO_IDLE;
      default:
        st_d = BYTIO_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_q  <= BYTIO_IDLE;
      cnt_q <= '0;
      wd_q  <= 8'h00;
      rd_q  <= 8'h00;
      rv_q  <= 1'b0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      wd_q  <= wd_d;
      rd_q  <= rd_d;
      rv_q  <= rv_d;
    end
  end

  // Pin drive decoded from state; selects only after the early step
  assign pins.mode         = MODE;
  assign pins.select_one   = (MODE == BYTIO_MODE_INPUT) &&
                             (st_q == BYTIO_SELECT || st_q == BYTIO_TAKE);
  // Output mode keeps the select one cycle past the strobe fall
  assign pins.select_two   = (st_q == BYTIO_SELECT || st_q == BYTIO_TAKE)
                             || ((MODE == BYTIO_MODE_OUTPUT) &&
                                 (st_q == BYTIO_PULSE ||
                                  st_q == BYTIO_DONE));
  assign pins.latch_enable = (st_q == BYTIO_PULSE);
  assign pins.clear_n      = user_clear_n;
  assign pins.port_in_bits = wd_q;
  assign user_busy         = (st_q != BYTIO_IDLE);
  assign user_rdata        = rd_q;
  assign user_rvalid       = rv_q;
  assign user_clear_n      = 1'b1;
endmodule
`default_nettype wire

/* File: tb/bytio_assertions.sv */
// Checker watching the input-mode port across its interface
`default_nettype none
module bytio_assertions
  import bytio_pkg::*;
(
  // System
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // Host driven pins
  input wire logic       mode,
  input wire logic       select_one,
  input wire logic       select_two,
  input wire logic       latch_enable,
  input wire logic       clear_n,
  input wire logic [7:0] port_in_bits,
  // Port driven pins
  input wire logic [7:0] port_out_bits,
  input wire logic       port_out_en,
  input wire logic       service_request
);
  wire logic sel = select_one && select_two;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Strobe fall and a quiet selected stretch
  sequence strobe_fall;
    !mode && $fell(latch_enable);
  endsequence
  sequence held_sel;
    (!mode && sel && !latch_enable && clear_n) [*2];
  endsequence
  req_strobe_a: assert property (strobe_fall |=> !service_request)
    else $error("request not low after strobe");
  oe_off_a: assert property (!mode && !sel |=> !port_out_en)
    else $error("driving while deselected");
  oe_on_a: assert property (!mode && sel |=> port_out_en)
    else $error("not driving while selected");
  req_sel_a: assert property (!mode && sel |=> !service_request)
    else $error("selection left request high");
  req_desel_a: assert property (!mode && $fell(sel) |=> service_request)
    else $error("request not high after deselect");
  data_pass_a: assert property (!mode && sel && latch_enable
    |=> port_out_bits == $past(port_in_bits)) else $error("pins not passed");
  data_hold_a: assert property (held_sel |=> $stable(port_out_bits))
    else $error("held byte moved");
  out_quiet_a: assert property (!port_out_en
    |-> port_out_bits == BYTIO_CLEAR_VALUE) else $error("bits while off");
endmodule
`default_nettype wire

/* File: tb/byte_io_port_handshake_bench.sv */
// Bench joining both port ends in input and in output mode
`default_nettype none
module byte_io_port_handshake_bench;
  import bytio_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       go_a = 1'b0;
  logic       go_b = 1'b0;
  logic [7:0] wd_a = 8'h00;
  logic [7:0] wd_b = 8'h00;
  logic [7:0] rd_a;
  logic       rv_a;
  logic       busy_b;
  int         error_cnt = 0;
  int         checks = 0;
  bytio_if u_if_in ();
  bytio_if u_if_out ();
  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;
  // Input pair, watched by the checker, and output pair
  bytio_port u_bytio_port (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .pins(u_if_in.port));
  bytio_port u_bytio_port_out (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .pins(u_if_out.port));
  bytio_host #(.MODE(BYTIO_MODE_INPUT)) u_bytio_host (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .user_go(go_a), .user_wdata(wd_a), .user_busy(),
    .user_rdata(rd_a), .user_rvalid(rv_a), .user_clear_n(),
    .pins(u_if_in.host));
  bytio_host #(.MODE(BYTIO_MODE_OUTPUT)) u_bytio_host_out (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .user_go(go_b), .user_wdata(wd_b), .user_busy(busy_b),
    .user_rdata(), .user_rvalid(), .user_clear_n(), .pins(u_if_out.host));
  bytio_assertions u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .mode(u_if_in.mode), .select_one(u_if_in.select_one),
    .select_two(u_if_in.select_two), .latch_enable(u_if_in.latch_enable),
    .clear_n(u_if_in.clear_n), .port_in_bits(u_if_in.port_in_bits),
    .port_out_bits(u_if_in.port_out_bits), .port_out_en(u_if_in.port_out_en),
    .service_request(u_if_in.service_request));
  // Compare and count; case inequality so unknowns fail
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  // Strobe a byte in, wait for the request, let the host read it
  task automatic test_input(input logic [7:0] b);
    @(posedge sys_clk);
    wd_a <= b;
    go_a <= 1'b1;
    @(posedge sys_clk);
    go_a <= 1'b0;
    for (int n = 0; n < 20 && u_if_in.service_request !== 1'b0; n++)
      @(negedge sys_clk);
    chk("req", 8'h00, {7'h00, u_if_in.service_request});
    chk("oe idle", 8'h00, {7'h00, u_if_in.port_out_en});
    for (int n = 0; n < 20 && rv_a !== 1'b1; n++)
      @(negedge sys_clk);
    chk("rdata", b, rd_a);
    repeat (3) @(negedge sys_clk);
    chk("req back", 8'h01, {7'h00, u_if_in.service_request});
    $display("input test done");
  endtask
  // Write a byte out; request drops at clock fall, rises on deselect
  task automatic test_output(input logic [7:0] b);
    @(posedge sys_clk);
    wd_b <= b;
    go_b <= 1'b1;
    @(posedge sys_clk);
    go_b <= 1'b0;
    for (int n = 0; n < 20 && u_if_out.latch_enable !== 1'b1; n++)
      @(negedge sys_clk);
    for (int n = 0; n < 20 && u_if_out.latch_enable !== 1'b0; n++)
      @(negedge sys_clk);
    for (int n = 0; n < 20 && u_if_out.service_request !== 1'b0; n++)
      @(negedge sys_clk);
    chk("req fall", 8'h00, {7'h00, u_if_out.service_request});
    for (int n = 0; n < 20 && u_if_out.service_request !== 1'b1; n++)
      @(negedge sys_clk);
    chk("req rise", 8'h01, {7'h00, u_if_out.service_request});
    chk("oe", 8'h01, {7'h00, u_if_out.port_out_en});
    chk("out", b, u_if_out.port_out_bits);
    $display("output test done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence: a pattern and the boundary bytes in, two writes out
  initial
  begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    test_input(8'hA5);
    test_input(8'h00);
    test_input(8'hFF);
    test_output(8'h3C);
    test_output(8'hC3);
    summarize();
  end
  // Watchdog well past the hundred or so cycles the tests need
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
